// >>> pmcrc_defines.svh
// Function
// - write byte0 starts 256-byte 16-bit checksum
// - block start address is written byte, 00
// - block result: byte1 msb, byte0 lsb
// - write byte1 starts 32-bit whole-memory checksum
// - whole-memory checksum starts at address 0000
// - whole result: byte3 msb down to byte0
// - halted device lends reset and data pins
`ifndef PMCRC_DEFINES_SVH
`define PMCRC_DEFINES_SVH
// =====================================================
// register offsets on the debug link
`define PMCRC_ADDR_BYTE0 8'hA9
`define PMCRC_ADDR_BYTE1 8'hAA
`define PMCRC_ADDR_BYTE2 8'hAB
`define PMCRC_ADDR_BYTE3 8'hAC
// =====================================================
// reset values and checksum defaults
`define PMCRC_RESULT_RESET 8'h00
`define PMCRC_BLOCK_LOW 8'h00
`define PMCRC_WHOLE_START 16'h0000
`define PMCRC_BLOCK_BYTES 17'h00100
`define PMCRC_POLY16 16'h1021
`define PMCRC_POLY32 32'h04C11DB7
`define PMCRC_SEED16 16'h0000
`define PMCRC_SEED32 32'h00000000
`endif

// >>> pmcrc_pkg.sv
package pmcrc_pkg;
    // =====================================================
    // register access from the debug link
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmcrc_req_t;
    // =====================================================
    // program memory read port
    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } pmcrc_mem_t;
    typedef enum logic [1:0] {
        PMCRC_IDLE  = 2'b00,
        PMCRC_READ  = 2'b01,
        PMCRC_ACCUM = 2'b10
    } pmcrc_state_t;
endpackage

// >>> pmcrc_engine.sv
`timescale 1ns/1ps
`include "pmcrc_defines.svh"
module pmcrc_engine import pmcrc_pkg::*; #(
    parameter int          PROG_BYTES = 65536,
    parameter logic [15:0] POLY16     = `PMCRC_POLY16,
    parameter logic [31:0] POLY32     = `PMCRC_POLY32,
    parameter logic [15:0] SEED16     = `PMCRC_SEED16,
    parameter logic [31:0] SEED32     = `PMCRC_SEED32
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire pmcrc_req_t i_req,
    output logic [7:0]      o_rdata,
    output pmcrc_mem_t      o_mem,
    input  wire logic [7:0] i_mem_data,
    input  wire logic       i_halted,
    output logic            o_pins_borrowed,
    output logic            o_busy
);
    // =====================================================
    // parameter check
    if (PROG_BYTES < 256 || PROG_BYTES > 65536 || (PROG_BYTES % 256) != 0) begin
        $error("PROG_BYTES must be a multiple of 256 up to 65536");
    end

    localparam logic [16:0] PROG_LEN = 17'(PROG_BYTES);

    // =====================================================
    // checksum step, one byte msb first
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d,
                                             input logic wide);
        logic [31:0] r;
        logic        fb;
        integer      i;
        r = c;
        for (i = 0; i < 8; i = i + 1) begin
            fb = (wide ? r[31] : r[15]) ^ d[7-i];
            r  = r << 1;
            if (fb) begin
                r = r ^ (wide ? POLY32 : {16'h0000, POLY16});
            end
        end
        if (!wide) begin
            r[31:16] = 16'h0000;
        end
        return r;
    endfunction

    // =====================================================
    // engine state
    pmcrc_state_t    state, next_state;
    logic            wide, next_wide;
    logic [15:0]     addr, next_addr;
    logic [16:0]     left, next_left;
    logic [31:0]     crc, next_crc;
    logic [3:0][7:0] result, next_result;
    logic [7:0]      next_rdata;
    logic            done;

    assign done = (state == PMCRC_ACCUM) && (left == 17'h00001);

    always_comb begin
        next_state  = state;
        next_wide   = wide;
        next_addr   = addr;
        next_left   = left;
        next_crc    = crc;
        next_result = result;
        unique case (state)
            PMCRC_IDLE: begin
                if (i_req.wr) begin
                    unique case (i_req.addr)
                        `PMCRC_ADDR_BYTE0: begin
                            next_result[0] = i_req.wdata;
                            next_state     = PMCRC_READ;
                            next_wide      = 1'b0;
                            next_addr      = {i_req.wdata, `PMCRC_BLOCK_LOW};
                            next_left      = `PMCRC_BLOCK_BYTES;
                            next_crc       = {16'h0000, SEED16};
                        end
                        `PMCRC_ADDR_BYTE1: begin
                            next_result[1] = i_req.wdata;
                            next_state     = PMCRC_READ;
                            next_wide      = 1'b1;
                            next_addr      = `PMCRC_WHOLE_START;
                            next_left      = PROG_LEN;
                            next_crc       = SEED32;
                        end
                        `PMCRC_ADDR_BYTE2: next_result[2] = i_req.wdata;
                        `PMCRC_ADDR_BYTE3: next_result[3] = i_req.wdata;
                        default: begin
                        end
                    endcase
                end
            end
            PMCRC_READ: begin
                next_state = PMCRC_ACCUM;
            end
            PMCRC_ACCUM: begin
                next_crc  = crc_step(crc, i_mem_data, wide);
                next_addr = addr + 16'h0001;
                next_left = left - 17'h00001;
                if (done) begin
                    next_state = PMCRC_IDLE;
                    if (wide) begin
                        next_result = next_crc;
                    end else begin
                        next_result[1] = next_crc[15:8];
                        next_result[0] = next_crc[7:0];
                    end
                end else begin
                    next_state = PMCRC_READ;
                end
            end
            default: next_state = PMCRC_IDLE;
        endcase
    end

    // =====================================================
    // read data decode
    always_comb begin
        unique case (i_req.addr)
            `PMCRC_ADDR_BYTE0: next_rdata = result[0];
            `PMCRC_ADDR_BYTE1: next_rdata = result[1];
            `PMCRC_ADDR_BYTE2: next_rdata = result[2];
            `PMCRC_ADDR_BYTE3: next_rdata = result[3];
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state           <= PMCRC_IDLE;
            wide            <= 1'b0;
            addr            <= 16'h0000;
            left            <= 17'h00000;
            crc             <= 32'h00000000;
            result          <= {4{`PMCRC_RESULT_RESET}};
            o_rdata         <= 8'h00;
            o_pins_borrowed <= 1'b0;
        end else begin
            state           <= next_state;
            wide            <= next_wide;
            addr            <= next_addr;
            left            <= next_left;
            crc             <= next_crc;
            result          <= next_result;
            o_rdata         <= next_rdata;
            o_pins_borrowed <= i_halted;
        end
    end

    assign o_mem.rd   = (state == PMCRC_READ);
    assign o_mem.addr = addr;
    assign o_busy     = (state != PMCRC_IDLE);

    // =====================================================
    // checks
    logic [16:0] seen;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen <= 17'h00000;
        end else if (state == PMCRC_IDLE) begin
            seen <= 17'h00000;
        end else if (state == PMCRC_ACCUM) begin
            seen <= seen + 17'h00001;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    start_block_a: assert property (
        state == PMCRC_IDLE && i_req.wr && i_req.addr == `PMCRC_ADDR_BYTE0
        |=> o_mem.rd && !wide && o_mem.addr == {$past(i_req.wdata), 8'h00})
        else $error("block checksum start address wrong");
    start_whole_a: assert property (
        state == PMCRC_IDLE && i_req.wr && i_req.addr == `PMCRC_ADDR_BYTE1
        |=> o_mem.rd && wide && o_mem.addr == 16'h0000)
        else $error("whole checksum start wrong");
    block_len_a: assert property (
        done && !wide |-> seen == 17'h000FF)
        else $error("block checksum length not 256");
    whole_len_a: assert property (
        done && wide |-> seen == PROG_LEN - 17'h00001)
        else $error("whole checksum length wrong");
    block_result_a: assert property (
        done && !wide |=> result[1] == crc[15:8] && result[0] == crc[7:0]
        && $stable(result[3]))
        else $error("block result misplaced");
    whole_result_a: assert property (
        done && wide |=> result == crc)
        else $error("whole result misplaced");
    busy_hold_a: assert property (
        o_busy && !done |=> $stable(result) && $stable(wide))
        else $error("results changed while busy");
    crc_narrow_a: assert property (
        o_busy && !wide |-> crc[31:16] == 16'h0000)
        else $error("block checksum wider than 16 bits");
    pin_share_a: assert property (
        $rose(i_halted) |=> o_pins_borrowed ##1 o_pins_borrowed || !i_halted)
        else $error("pins not lent while halted");
    mem_strobe_a: assert property (
        o_mem.rd |=> !o_mem.rd)
        else $error("memory strobe longer than one cycle");
    addr_step_a: assert property (
        state == PMCRC_ACCUM && !done
        |=> o_mem.rd && o_mem.addr == $past(addr) + 16'h0001)
        else $error("checksum address did not advance by one");
    busy_count_a: assert property (
        state == PMCRC_READ |=> left == $past(left) && crc == $past(crc))
        else $error("checksum restarted while busy");

    // =====================================================
    // scenario covers
    block_run_c: cover property (done && !wide);
    whole_run_c: cover property (done && wide);
    busy_write_c: cover property (o_busy && i_req.wr);
    busy_refuse_c: cover property (o_busy && i_req.wr && i_req.addr == `PMCRC_ADDR_BYTE1);
    pins_back_c: cover property ($rose(i_halted));
endmodule

// >>> pmcrc_mem_model.sv
`timescale 1ns/1ps
module pmcrc_mem_model import pmcrc_pkg::*; (
    input  wire logic       i_clk,
    input  wire pmcrc_mem_t i_mem,
    output logic [7:0]      o_data
);
    // =====================================================
    // program memory, byte valid the cycle after the strobe
    initial o_data = 8'hA5;
    always @(posedge i_clk) begin
        if (i_mem.rd) begin
            o_data <= i_mem.addr[7:0] ^ i_mem.addr[15:8] ^ 8'h5A;
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule

// >>> tb_program_memory_crc_engine.sv
`timescale 1ns/1ps
`include "pmcrc_defines.svh"
module tb_program_memory_crc_engine import pmcrc_pkg::*;;
    localparam int PROG = 512;
    logic       i_clk     = 1'b0;
    logic       i_reset_n = 1'b0;
    pmcrc_req_t req       = '0;
    logic       halted    = 1'b1;
    logic [7:0] rdata;
    logic [7:0] mem_data;
    pmcrc_mem_t mem;
    logic       borrowed;
    logic       busy;
    logic [31:0] crc;
    int         bad_count   = 0;
    int         check_count = 0;

    always #4 i_clk = ~i_clk;

    pmcrc_engine #(.PROG_BYTES(PROG)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req), .o_rdata(rdata),
        .o_mem(mem), .i_mem_data(mem_data), .i_halted(halted),
        .o_pins_borrowed(borrowed), .o_busy(busy));
    pmcrc_mem_model partner (.i_clk(i_clk), .i_mem(mem), .o_data(mem_data));

    // =====================================================
    // helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge i_clk);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge i_clk);
        req.addr = a;
        @(negedge i_clk);
        chk(rdata, exp);
    endtask

    task automatic wait_done;
        int n;
        n = 0;
        chk({7'h0, busy}, 8'h01);
        while (busy === 1'b1 && n < 3000) begin
            @(negedge i_clk);
            n++;
        end
        chk({7'h0, busy}, 8'h00);
    endtask

    function automatic logic [31:0] crc_of(input int w, input logic [15:0] s, input int n);
        logic [31:0] c;
        logic [31:0] poly;
        logic [15:0] a;
        logic [7:0]  b;
        c = 32'h0;
        poly = (w == 16) ? {16'h0, `PMCRC_POLY16} : `PMCRC_POLY32;
        for (int i = 0; i < n; i++) begin
            a = s + i[15:0];
            b = a[7:0] ^ a[15:8] ^ 8'h5A;
            for (int k = 7; k >= 0; k--) begin
                if (c[w-1] ^ b[k]) c = (c << 1) ^ poly;
                else c = c << 1;
            end
        end
        return (w == 16) ? (c & 32'h0000FFFF) : c;
    endfunction

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // =====================================================
    // tests, with the device halted except while the pins are checked to come back
    initial begin
        repeat (12) @(negedge i_clk);
        i_reset_n = 1'b1;
        @(negedge i_clk);
        chk({7'h0, borrowed}, 8'h01);
        for (int i = 0; i < 4; i++) rd(`PMCRC_ADDR_BYTE0 + 8'(i), 8'h00);
        rd(8'h00, 8'h00);
        wr(`PMCRC_ADDR_BYTE2, 8'h5A);
        wr(`PMCRC_ADDR_BYTE3, 8'hC3);
        wr(`PMCRC_ADDR_BYTE0, 8'hFF);
        chk({7'h0, mem.rd}, 8'h01);
        chk(mem.addr[15:8], 8'hFF);
        chk(mem.addr[7:0], 8'h00);
        wr(`PMCRC_ADDR_BYTE2, 8'h11);
        wr(`PMCRC_ADDR_BYTE1, 8'h00);
        wait_done;
        crc = crc_of(16, 16'hFF00, 256);
        rd(`PMCRC_ADDR_BYTE0, crc[7:0]);
        rd(`PMCRC_ADDR_BYTE1, crc[15:8]);
        rd(`PMCRC_ADDR_BYTE2, 8'h5A);
        rd(`PMCRC_ADDR_BYTE3, 8'hC3);
        wr(`PMCRC_ADDR_BYTE1, 8'h77);
        chk(mem.addr[15:8], 8'h00);
        chk(mem.addr[7:0], 8'h00);
        wait_done;
        crc = crc_of(32, 16'h0000, PROG);
        for (int i = 0; i < 4; i++) rd(`PMCRC_ADDR_BYTE0 + 8'(i), crc[8*i+:8]);
        halted = 1'b0;
        repeat (2) @(negedge i_clk);
        chk({7'h0, borrowed}, 8'h00);
        halted = 1'b1;
        repeat (3) @(negedge i_clk);
        chk({7'h0, borrowed}, 8'h01);
        report_and_stop;
    end

    initial begin
        #40000;
        bad_count++;
        report_and_stop;
    end
endmodule
